// [design/dclh_pkg.sv]
// Purpose: constants, types and crc step for the daisy chain link host
// Assumes: 10 MHz core clock, host drives serial clock and chip select
// Notes: check code is a 15-bit crc, seed 0x0010

package dclh_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CORE_CLK_MHZ = 10;
  localparam int SCK_HALF_NS = 400;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);
  // wake spacing must sit above the ready time and below the idle timeout
  localparam int WAKE_GAP_NS = 300000;
  localparam int WAKE_GAP_CYC = (WAKE_GAP_NS / 1000) * CORE_CLK_MHZ;
  localparam logic [11:0] WAKE_LAST = 12'(WAKE_GAP_CYC - 1);

  // ----------------------------------------
  // framing
  // ----------------------------------------
  localparam logic [14:0] CRC_SEED = 15'h0010;
  localparam logic [7:0] CMD_BYTES = 8'h04;
  localparam logic [2:0] GRP_DATA_LAST = 3'h5;
  localparam logic [2:0] GRP_PEC_HI = 3'h6;
  localparam logic [2:0] GRP_PEC_LO = 3'h7;
  localparam logic [7:0] DUMMY_BYTE = 8'hff;
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_READ = 2'h2;
  localparam logic [1:0] KIND_POLL = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAKE_LO = 3'b001,
    ST_WAKE_HI = 3'b010,
    ST_LEAD = 3'b011,
    ST_SHIFT = 3'b100,
    ST_POLL = 3'b101,
    ST_TRAIL = 3'b110,
    ST_GAP = 3'b111
  } dclh_state_e;

  typedef struct packed {
    dclh_state_e state;
    logic [1:0] kind;
    logic [10:0] cmdCode;
    logic [3:0] devCount;
    logic [7:0] total;
    logic [7:0] byteIdx;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic [7:0] rxPec0;
    logic [7:0] rdByte;
    logic [2:0] bitCnt;
    logic [3:0] half;
    logic [11:0] gap;
    logic [3:0] wakeCnt;
    logic [4:0] pollCnt;
    logic [14:0] txCrc;
    logic [14:0] rxCrc;
    logic sck;
    logic csN;
    logic hostOut;
    logic wrReq;
    logic rdValid;
    logic grpValid;
    logic grpPecOk;
    logic busy;
    logic done;
    logic pollDone;
    logic sdoMeta;
    logic sdoSync;
  } dclh_regs_s;

  function automatic logic [14:0] crcStep(input logic [14:0] c, input logic din);
    logic fb;
    logic [14:0] n;
    fb = din ^ c[14];
    n = {c[13:0], fb};
    n[3] = fb ^ c[2];
    n[4] = fb ^ c[3];
    n[7] = fb ^ c[6];
    n[8] = fb ^ c[7];
    n[10] = fb ^ c[9];
    n[14] = fb ^ c[13];
    return n;
  endfunction

endpackage

// [design/dclh_host.sv]
// Purpose: host end of a daisy chained battery monitor serial link
// Assumes: serial clock made here by a divider, mode 0, msb first
// Notes: one command per request; user paces write bytes
//
// Operation
// - wake pairs per device, spaced within window
// - whole bytes, most significant bit first
// - chip select low for whole sequence
// - 15-bit crc, fixed polynomial, printed seed
// - feedback is input xor top bit
// - check word is crc with zero appended
// - check bytes carry crc high then low
// - command, command, check, check order
// - write groups sent farthest device first
// - status valid only after N poll clocks
// - command byte 0 top five bits zero
// - missing returned pulse reads as one
`timescale 1ns/10ps

module dclh_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // request
  input wire logic cmdStart,
  input wire logic wakeStart,
  input wire logic [1:0] cmdKind,
  input wire logic [10:0] cmdCode,
  input wire logic [3:0] devCount,
  input wire logic pollAbort,
  // write data
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrReq,
  // read data
  output logic [7:0] rdByte,
  output logic rdValid,
  output logic grpValid,
  output logic grpPecOk,
  // status
  output logic busy,
  output logic done,
  output logic pollDone,
  // link pins
  output logic chipSelectN,
  output logic serialClk,
  output logic hostDataOut,
  input wire logic serialDataOut
);

  dclh_pkg::dclh_regs_s r_reg;
  dclh_pkg::dclh_regs_s r_next;
  logic halfEnd;
  logic bitIn;
  logic isData;
  logic [2:0] off;
  logic [2:0] nOff;
  logic [7:0] nIdx;
  logic [7:0] nextByte;
  logic [7:0] rxFull;
  logic [14:0] txCrcUpd;
  logic [14:0] rxCrcUpd;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.rdValid = 1'b0;
    r_next.grpValid = 1'b0;
    r_next.done = 1'b0;
    r_next.pollDone = 1'b0;
    r_next.sdoMeta = serialDataOut;
    r_next.sdoSync = r_reg.sdoMeta;
    halfEnd = (r_reg.half == dclh_pkg::HALF_LAST);
    bitIn = r_reg.sdoSync;
    off = 3'(r_reg.byteIdx - dclh_pkg::CMD_BYTES);
    nIdx = r_reg.byteIdx + 8'h01;
    nOff = 3'(nIdx - dclh_pkg::CMD_BYTES);
    isData = (r_reg.byteIdx >= dclh_pkg::CMD_BYTES) && (off <= dclh_pkg::GRP_DATA_LAST);
    rxFull = {r_reg.rxShift[6:0], bitIn};
    txCrcUpd = r_reg.txCrc;
    if (r_reg.byteIdx < 8'h02 || (isData && r_reg.kind == dclh_pkg::KIND_WRITE)) begin
      txCrcUpd = dclh_pkg::crcStep(r_reg.txCrc, r_reg.txShift[7]);
    end
    rxCrcUpd = r_reg.rxCrc;
    if (isData && r_reg.kind == dclh_pkg::KIND_READ) begin
      rxCrcUpd = dclh_pkg::crcStep(r_reg.rxCrc, bitIn);
    end
    nextByte = dclh_pkg::DUMMY_BYTE;
    if (nIdx < dclh_pkg::CMD_BYTES) begin
      case (nIdx[1:0])
        2'h1: nextByte = r_reg.cmdCode[7:0];
        2'h2: nextByte = txCrcUpd[14:7];
        default: nextByte = {txCrcUpd[6:0], 1'b0};
      endcase
    end else if (nOff == dclh_pkg::GRP_PEC_HI && r_reg.kind == dclh_pkg::KIND_WRITE) begin
      nextByte = txCrcUpd[14:7];
    end else if (nOff == dclh_pkg::GRP_PEC_LO && r_reg.kind == dclh_pkg::KIND_WRITE) begin
      nextByte = {txCrcUpd[6:0], 1'b0};
    end
    case (r_reg.state)
      dclh_pkg::ST_IDLE: begin
        if (cmdStart) begin
          r_next.kind = cmdKind;
          r_next.cmdCode = cmdCode;
          r_next.devCount = devCount;
          r_next.total = dclh_pkg::CMD_BYTES;
          if (cmdKind == dclh_pkg::KIND_WRITE || cmdKind == dclh_pkg::KIND_READ) begin
            r_next.total = dclh_pkg::CMD_BYTES + {1'b0, devCount, 3'h0};
          end
          r_next.byteIdx = 8'h00;
          r_next.bitCnt = 3'h0;
          r_next.txShift = {5'h00, cmdCode[10:8]};
          r_next.hostOut = 1'b0;
          r_next.txCrc = dclh_pkg::CRC_SEED;
          r_next.csN = 1'b0;
          r_next.busy = 1'b1;
          r_next.half = 4'h0;
          r_next.state = dclh_pkg::ST_LEAD;
        end else if (wakeStart) begin
          r_next.kind = dclh_pkg::KIND_CMD;
          r_next.devCount = devCount;
          r_next.wakeCnt = 4'h0;
          r_next.gap = 12'h000;
          r_next.csN = 1'b0;
          r_next.busy = 1'b1;
          r_next.state = dclh_pkg::ST_WAKE_LO;
        end
      end
      dclh_pkg::ST_WAKE_LO: begin
        r_next.gap = r_reg.gap + 12'h001;
        if (r_reg.gap == dclh_pkg::WAKE_LAST) begin
          r_next.gap = 12'h000;
          r_next.csN = 1'b1;
          r_next.state = dclh_pkg::ST_WAKE_HI;
        end
      end
      dclh_pkg::ST_WAKE_HI: begin
        r_next.gap = r_reg.gap + 12'h001;
        if (r_reg.gap == dclh_pkg::WAKE_LAST) begin
          r_next.gap = 12'h000;
          r_next.wakeCnt = r_reg.wakeCnt + 4'h1;
          if (r_reg.wakeCnt + 4'h1 >= r_reg.devCount) begin
            r_next.half = 4'h0;
            r_next.state = dclh_pkg::ST_GAP;
          end else begin
            r_next.csN = 1'b0;
            r_next.state = dclh_pkg::ST_WAKE_LO;
          end
        end
      end
      dclh_pkg::ST_LEAD: begin
        r_next.half = r_reg.half + 4'h1;
        if (halfEnd) begin
          r_next.half = 4'h0;
          r_next.state = dclh_pkg::ST_SHIFT;
        end
      end
      dclh_pkg::ST_SHIFT, dclh_pkg::ST_POLL: begin
        if (r_reg.wrReq) begin
          // clock stays low while the user has no byte ready
          if (wrValid) begin
            r_next.txShift = wrData;
            r_next.hostOut = wrData[7];
            r_next.wrReq = 1'b0;
          end
        end else begin
          r_next.half = r_reg.half + 4'h1;
          if (halfEnd) begin
            r_next.half = 4'h0;
            r_next.sck = ~r_reg.sck;
            if (r_reg.sck) begin
              r_next.txShift = {r_reg.txShift[6:0], 1'b1};
              r_next.hostOut = r_reg.txShift[6];
              r_next.rxShift = rxFull;
              r_next.txCrc = txCrcUpd;
              r_next.rxCrc = rxCrcUpd;
              r_next.bitCnt = r_reg.bitCnt + 3'h1;
              if (r_reg.state == dclh_pkg::ST_POLL) begin
                r_next.hostOut = 1'b1;
                if (r_reg.pollCnt != 5'h1f) begin
                  r_next.pollCnt = r_reg.pollCnt + 5'h01;
                end
                if (pollAbort || (bitIn && (r_reg.pollCnt + 5'h01) >= {1'b0, r_reg.devCount})) begin
                  r_next.pollDone = ~pollAbort;
                  r_next.half = 4'h0;
                  r_next.state = dclh_pkg::ST_TRAIL;
                end
              end else if (r_reg.bitCnt == 3'h7) begin
                if (isData && r_reg.kind == dclh_pkg::KIND_READ) begin
                  r_next.rdByte = rxFull;
                  r_next.rdValid = 1'b1;
                end
                if (r_reg.byteIdx >= dclh_pkg::CMD_BYTES && off == dclh_pkg::GRP_PEC_HI) begin
                  r_next.rxPec0 = rxFull;
                end
                if (r_reg.byteIdx >= dclh_pkg::CMD_BYTES && off == dclh_pkg::GRP_PEC_LO
                    && r_reg.kind == dclh_pkg::KIND_READ) begin
                  r_next.grpValid = 1'b1;
                  r_next.grpPecOk = ({r_reg.rxPec0, rxFull} == {r_reg.rxCrc, 1'b0});
                end
                r_next.byteIdx = nIdx;
                if (nIdx == r_reg.total) begin
                  r_next.half = 4'h0;
                  r_next.pollCnt = 5'h00;
                  r_next.hostOut = 1'b1;
                  r_next.state = (r_reg.kind == dclh_pkg::KIND_POLL) ? dclh_pkg::ST_POLL : dclh_pkg::ST_TRAIL;
                end else begin
                  r_next.txShift = nextByte;
                  r_next.hostOut = nextByte[7];
                  if (nIdx >= dclh_pkg::CMD_BYTES && nOff == 3'h0) begin
                    r_next.txCrc = dclh_pkg::CRC_SEED;
                    r_next.rxCrc = dclh_pkg::CRC_SEED;
                  end
                  if (nIdx >= dclh_pkg::CMD_BYTES && nOff <= dclh_pkg::GRP_DATA_LAST
                      && r_reg.kind == dclh_pkg::KIND_WRITE) begin
                    r_next.wrReq = 1'b1;
                  end
                end
              end
            end
          end
        end
      end
      dclh_pkg::ST_TRAIL: begin
        r_next.half = r_reg.half + 4'h1;
        if (halfEnd) begin
          r_next.half = 4'h0;
          r_next.csN = 1'b1;
          r_next.state = dclh_pkg::ST_GAP;
        end
      end
      dclh_pkg::ST_GAP: begin
        r_next.half = r_reg.half + 4'h1;
        if (halfEnd) begin
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.state = dclh_pkg::ST_IDLE;
        end
      end
      default: r_next.state = dclh_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.csN <= 1'b1;
      r_reg.sdoMeta <= 1'b1;
      r_reg.sdoSync <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wrReq = r_reg.wrReq;
  assign rdByte = r_reg.rdByte;
  assign rdValid = r_reg.rdValid;
  assign grpValid = r_reg.grpValid;
  assign grpPecOk = r_reg.grpPecOk;
  assign busy = r_reg.busy;
  assign done = r_reg.done;
  assign pollDone = r_reg.pollDone;
  assign chipSelectN = r_reg.csN;
  assign serialClk = r_reg.sck;
  assign hostDataOut = r_reg.hostOut;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  function automatic logic [14:0] cmdPec(input logic [10:0] cc);
    logic [14:0] c;
    logic [15:0] w;
    c = dclh_pkg::CRC_SEED;
    w = {5'h00, cc};
    for (int i = 15; i >= 0; i--) begin
      c = dclh_pkg::crcStep(c, w[i]);
    end
    return c;
  endfunction

  // reference check word, so properties can slice it
  logic [14:0] cmdPecRef;
  assign cmdPecRef = cmdPec(r_reg.cmdCode);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  csHeld_a: assert property ((r_reg.state == dclh_pkg::ST_SHIFT || r_reg.state == dclh_pkg::ST_POLL) |-> !chipSelectN)
    else $error("chip select high during a sequence");
  sckGate_a: assert property (chipSelectN |-> !serialClk)
    else $error("serial clock high with chip select high");
  mosiStable_a: assert property ($rose(serialClk) |=> $stable(hostDataOut) [*3])
    else $error("data changed while serial clock high");
  byteWhole_a: assert property ((r_reg.state == dclh_pkg::ST_SHIFT && $changed(r_reg.byteIdx)) |-> ($past(r_reg.bitCnt) == 3'h7))
    else $error("byte advanced before eight bits");
  cmdFirst_a: assert property ((r_reg.state == dclh_pkg::ST_LEAD) |-> (r_reg.txShift == {5'h00, r_reg.cmdCode[10:8]}))
    else $error("command byte 0 malformed");
  cmdPecHi_a: assert property ((r_reg.state == dclh_pkg::ST_SHIFT && r_reg.byteIdx == 8'h02 && r_reg.bitCnt == 3'h0
      && r_reg.half == 4'h0 && !r_reg.sck) |-> (r_reg.txShift == cmdPecRef[14:7]))
    else $error("wrong high check byte");
  cmdPecLo_a: assert property ((r_reg.state == dclh_pkg::ST_SHIFT && r_reg.byteIdx == 8'h03 && r_reg.bitCnt == 3'h0
      && r_reg.half == 4'h0 && !r_reg.sck) |-> (r_reg.txShift == {cmdPecRef[6:0], 1'b0}))
    else $error("wrong low check byte");
  pollWait_a: assert property (pollDone |-> (r_reg.pollCnt >= {1'b0, r_reg.devCount}) && $past(r_reg.sdoSync))
    else $error("poll finished before N clocks");
  wakeGap_a: assert property ((r_reg.state == dclh_pkg::ST_WAKE_HI && $past(r_reg.state) == dclh_pkg::ST_WAKE_LO)
      |-> ($past(r_reg.gap) == dclh_pkg::WAKE_LAST))
    else $error("wake pulse spacing wrong");
  writeLen_a: assert property ((done && r_reg.kind == dclh_pkg::KIND_WRITE) |-> (r_reg.byteIdx == r_reg.total))
    else $error("write ended with wrong byte count");
  grpSeed_a: assert property ((r_reg.state == dclh_pkg::ST_SHIFT && r_reg.byteIdx >= 8'h04 && r_reg.byteIdx[2:0] == 3'h4
      && r_reg.bitCnt == 3'h0 && r_reg.half == 4'h0 && !r_reg.sck) |-> (r_reg.rxCrc == dclh_pkg::CRC_SEED))
    else $error("group crc not reseeded");

  writeDone_c: cover property (done && r_reg.kind == dclh_pkg::KIND_WRITE);
  readGood_c: cover property (grpValid && grpPecOk);
  pollDone_c: cover property (pollDone);
  wakeDone_c: cover property (done && r_reg.wakeCnt != 4'h0);

endmodule

// [dv/dclh_dev_chain.sv]
// Purpose: behavioural chain of monitor devices on the host link
// Assumes: direct serial mode, data out pulled high when not driven
// Notes: pulse mode replies are not modelled; command codes are arbitrary
`timescale 1ns/10ps

module dclh_dev_chain #(
  parameter int DEVS = 3,
  parameter logic [10:0] WR_CODE = 11'h001,
  parameter logic [10:0] RD_CODE = 11'h002,
  parameter logic [10:0] POLL_CODE = 11'h714
) (
  // link pins
  input wire logic chipSelectN,
  input wire logic serialClk,
  input wire logic hostDataOut,
  output logic serialDataOut,
  // test controls
  input wire logic [DEVS-1:0] busyMask,
  input wire logic badPec
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  int bitCnt = 0;
  int frameBits = 0;
  logic grpBad = 1'b0;
  logic cmdPecOk;
  logic [63:0] sh;
  logic [15:0] cmdWord = 16'hffff;
  logic [7:0] mem [DEVS][6];
  logic [7:0] wrBuf [DEVS][6];
  logic outBits [DEVS*64];

  function automatic logic [14:0] crc15(input logic [63:0] bits, input int n);
    logic [14:0] c;
    logic fb;
    c = 15'h0010;
    for (int i = n - 1; i >= 0; i--) begin
      fb = bits[i] ^ c[14];
      c = {c[13:0], fb} ^ ({15{fb}} & 15'h4598);
    end
    return c;
  endfunction

  function automatic logic [15:0] pecWord(input logic [63:0] bits, input int n);
    return {crc15(bits, n), 1'b0};
  endfunction

  initial begin
    serialDataOut = 1'b1;
    for (int d = 0; d < DEVS; d++) begin
      for (int b = 0; b < 6; b++) begin
        mem[d][b] = 8'(16 * d + b);
      end
    end
  end

  // msb first, every device sees the command
  always @(posedge serialClk) begin
    logic [63:0] grp;
    if (!chipSelectN) begin
      sh = {sh[62:0], hostDataOut};
      bitCnt++;
      // command taken whatever its check; the check result goes to cmdPecOk
      if (bitCnt == 32) begin
        cmdWord = sh[31:16];
        cmdPecOk = (sh[15:0] === pecWord({48'h0, sh[31:16]}, 16)) && (sh[31:27] === 5'h0);
        // own group first, then the upper ones
        if (sh[26:16] === RD_CODE) begin
          for (int d = 0; d < DEVS; d++) begin
            for (int b = 0; b < 6; b++) begin
              grp[63 - 8 * b -: 8] = mem[d][b];
            end
            grp[15:0] = pecWord({16'h0, grp[63:16]}, 48);
            if (badPec && d == 0) begin
              grp[8] = ~grp[8];
            end
            for (int i = 0; i < 64; i++) begin
              outBits[64 * d + i] = grp[63 - i];
            end
          end
        end
      end
      // first group belongs to the farthest device
      if (bitCnt > 32 && (bitCnt - 32) % 64 == 0 && cmdWord[10:0] === WR_CODE && bitCnt <= 32 + 64 * DEVS) begin
        if (sh[15:0] !== pecWord({16'h0, sh[63:16]}, 48)) begin
          grpBad = 1'b1;
        end
        for (int b = 0; b < 6; b++) begin
          wrBuf[DEVS - (bitCnt - 32) / 64][b] = sh[63 - 8 * b -: 8];
        end
      end
    end
  end

  // low for N clocks, then low while any busy
  always @(negedge serialClk) begin
    if (!chipSelectN && bitCnt >= 32) begin
      if (cmdWord[10:0] === RD_CODE && bitCnt < 32 + 64 * DEVS) begin
        serialDataOut <= outBits[bitCnt - 32];
      end else if (cmdWord[10:0] === POLL_CODE) begin
        serialDataOut <= (bitCnt - 32 >= DEVS) && !(|busyMask);
      end else begin
        serialDataOut <= 1'b1;
      end
    end
  end

  // rise ends polling and commits whole writes
  always @(posedge chipSelectN) begin
    serialDataOut <= 1'b1;
    frameBits = bitCnt;
    if (cmdWord[10:0] === WR_CODE && bitCnt == 32 + 64 * DEVS && !grpBad) begin
      for (int d = 0; d < DEVS; d++) begin
        mem[d] = wrBuf[d];
      end
    end
  end

  always @(negedge chipSelectN) begin
    bitCnt = 0;
    grpBad = 1'b0;
  end
endmodule

// [dv/tb_daisy_chain_serial_link_layer.sv]
// Purpose: self-checking bench for the daisy chain link host
// Assumes: chain of three modelled devices in direct serial mode
// Notes: the host makes the serial clock, so the bench makes none
`timescale 1ns/10ps

module tb_daisy_chain_serial_link_layer;
  localparam int DEVS = 3;
  localparam logic [10:0] WR_CODE = 11'h001;
  localparam logic [10:0] RD_CODE = 11'h002;
  localparam logic [10:0] POLL_CODE = 11'h714;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic core_clk, rst_n, cmdStart, wakeStart, pollAbort, wrValid, wrReq, rdValid, grpValid, grpPecOk;
  logic busy, done, pollDone, chipSelectN, serialClk, hostDataOut, serialDataOut, badPec;
  logic [1:0] cmdKind;
  logic [10:0] cmdCode;
  logic [3:0] devCount;
  logic [7:0] wrData, rdByte;
  logic [DEVS-1:0] busyMask;
  int miscompares = 0, compares = 0, wrIdx = 0, pollSeen = 0, falls = 0;
  realtime tFall = 0, tRise = 0, lowNs = 0, highNs = 0;
  logic [7:0] wrBytes [18];
  logic [7:0] rdQ [$];
  logic okQ [$];

  dclh_host dut (.core_clk(core_clk), .rst_n(rst_n), .cmdStart(cmdStart), .wakeStart(wakeStart),
    .cmdKind(cmdKind), .cmdCode(cmdCode), .devCount(devCount), .pollAbort(pollAbort), .wrData(wrData),
    .wrValid(wrValid), .wrReq(wrReq), .rdByte(rdByte), .rdValid(rdValid), .grpValid(grpValid),
    .grpPecOk(grpPecOk), .busy(busy), .done(done), .pollDone(pollDone), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .hostDataOut(hostDataOut), .serialDataOut(serialDataOut));
  dclh_dev_chain #(.DEVS(DEVS), .WR_CODE(WR_CODE), .RD_CODE(RD_CODE), .POLL_CODE(POLL_CODE)) link (
    .chipSelectN(chipSelectN), .serialClk(serialClk), .hostDataOut(hostDataOut),
    .serialDataOut(serialDataOut), .busyMask(busyMask), .badPec(badPec));

  // ----------------------------------------
  // drivers and monitors
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    wrValid <= wrReq;
    wrData <= wrBytes[wrIdx % 18];
  end
  always @(posedge core_clk) begin
    if (wrReq === 1'b1 && wrValid === 1'b1) wrIdx <= wrIdx + 1;
    if (rdValid === 1'b1) rdQ.push_back(rdByte);
    if (grpValid === 1'b1) okQ.push_back(grpPecOk);
    if (pollDone === 1'b1) pollSeen <= pollSeen + 1;
  end
  always @(negedge chipSelectN) begin
    falls++;
    highNs = $realtime - tRise;
    tFall = $realtime;
  end
  always @(posedge chipSelectN) begin
    lowNs = $realtime - tFall;
    tRise = $realtime;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one request, bounded wait for its done pulse
  task automatic run(input logic wake, input logic [1:0] kind, input logic [10:0] code);
    int n;
    n = 0;
    @(negedge core_clk);
    cmdKind = kind;
    cmdCode = code;
    cmdStart = !wake;
    wakeStart = wake;
    @(negedge core_clk);
    cmdStart = 1'b0;
    wakeStart = 1'b0;
    check("busy", busy, 1'b1);
    while (done !== 1'b1 && n < 30000) begin
      @(negedge core_clk);
      n++;
    end
    check("done", done, 1'b1);
    @(negedge core_clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reference word
  task automatic tCrc();
    check("crcRef", link.pecWord(64'h1, 16), 16'h3d6e);
  endtask

  task automatic tCmd();
    run(1'b0, dclh_pkg::KIND_CMD, 11'h560);
    check("cmdWord", link.cmdWord, 16'h0560);
    check("cmdPec", link.cmdPecOk, 1'b1);
    check("cmdBits", link.frameBits, 32);
    check("idleOut", serialDataOut, 1'b1);
  endtask

  task automatic tWrite();
    run(1'b0, dclh_pkg::KIND_WRITE, WR_CODE);
    check("wrBits", link.frameBits, 32 + 64 * DEVS);
    check("wrPec", link.grpBad, 1'b0);
    for (int i = 0; i < 18; i++) begin
      check("wrMem", link.mem[DEVS - 1 - i / 6][i % 6], wrBytes[i]);
    end
  endtask

  task automatic tRead();
    rdQ.delete();
    okQ.delete();
    run(1'b0, dclh_pkg::KIND_READ, RD_CODE);
    check("rdCount", rdQ.size(), 6 * DEVS);
    for (int i = 0; i < 6 * DEVS && i < rdQ.size(); i++) begin
      check("rdByte", rdQ[i], wrBytes[6 * (DEVS - 1 - i / 6) + i % 6]);
    end
    for (int g = 0; g < DEVS; g++) begin
      check("rdPecOk", okQ[g], 1'b1);
    end
    okQ.delete();
    badPec = 1'b1;
    run(1'b0, dclh_pkg::KIND_READ, RD_CODE);
    badPec = 1'b0;
    check("badPec0", okQ[0], 1'b0);
    check("badPec1", okQ[1], 1'b1);
  endtask

  // poll waits for the whole chain
  task automatic tPoll();
    pollSeen = 0;
    busyMask = '1;
    fork
      run(1'b0, dclh_pkg::KIND_POLL, POLL_CODE);
      begin
        repeat (400) @(negedge core_clk);
        busyMask = '0;
      end
    join
    check("pollLong", link.frameBits > 33 + DEVS, 1'b1);
    check("pollDone", pollSeen, 1);
    pollSeen = 0;
    run(1'b0, dclh_pkg::KIND_POLL, POLL_CODE);
    check("pollBits", link.frameBits, 33 + DEVS);
    check("pollDone2", pollSeen, 1);
  endtask

  task automatic tAbort();
    pollSeen = 0;
    busyMask = 3'b010;
    fork
      run(1'b0, dclh_pkg::KIND_POLL, POLL_CODE);
      begin
        repeat (400) @(negedge core_clk);
        pollAbort = 1'b1;
      end
    join
    pollAbort = 1'b0;
    busyMask = '0;
    check("abortDone", pollSeen, 0);
    check("abortOut", serialDataOut, 1'b1);
  endtask

  task automatic tWake();
    int f0;
    f0 = falls;
    run(1'b1, dclh_pkg::KIND_CMD, 11'h000);
    check("wakePairs", falls - f0, DEVS);
    check("wakeLow", int'(lowNs), dclh_pkg::WAKE_GAP_CYC * 100);
    check("wakeHigh", int'(highNs), dclh_pkg::WAKE_GAP_CYC * 100);
  endtask

  initial begin
    rst_n = 1'b0;
    {cmdStart, wakeStart, pollAbort, badPec, wrValid} = '0;
    cmdKind = 2'h0;
    cmdCode = 11'h000;
    devCount = 4'(DEVS);
    wrData = 8'h00;
    busyMask = '0;
    for (int i = 0; i < 18; i++) begin
      wrBytes[i] = 8'ha0 + 8'(i);
    end
    repeat (6) @(negedge core_clk);
    check("rstCs", chipSelectN, 1'b1);
    check("rstClk", serialClk, 1'b0);
    rst_n = 1'b1;
    tCrc();
    tCmd();
    tWrite();
    tRead();
    tPoll();
    tAbort();
    tWake();
    summarize();
  end

  // watchdog: the whole sequence needs well under 40000 cycles
  initial begin
    repeat (80000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule
